// ===== raise_lower_ramp_reference_test.sv
`timescale 1ns/10ps
`default_nettype none
module raise_lower_ramp_reference_test;
    import rlr_pkg::*;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic [7:0]        addr = 8'h00;
    logic [31:0]       wdata = 32'h0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [31:0]       rdata;
    logic              w_rst = 1'b0;
    logic              w_up = 1'b0;
    logic              w_dn = 1'b0;
    logic              c_rst, c_up, c_dn, nv_ok, active;
    logic [15:0]       nv_lvl, level;
    int                miscompares = 0;
    int                n_checks = 0;
    int                cycles = 0;

    rlr_top #(.TICK_CYCLES(8)) u_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cmd_reset(c_rst),
        .i_cmd_raise(c_up), .i_cmd_lower(c_dn), .i_nv_valid(nv_ok), .i_nv_level(nv_lvl),
        .o_level(level), .o_active(active));
    rlr_switch_model u_sw (.i_ref_clk(clk), .i_want_reset(w_rst), .i_want_raise(w_up),
        .i_want_lower(w_dn), .i_active(active), .i_level(level), .o_cmd_reset(c_rst),
        .o_cmd_raise(c_up), .o_cmd_lower(c_dn), .o_nv_valid(nv_ok), .o_nv_level(nv_lvl));

    // ------------------------------------------------------------
    // clock, watchdog, helpers
    // ------------------------------------------------------------
    initial
    begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= {16'h0000, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    // polls under a bound, then compares once
    task automatic wait_lvl(input logic [15:0] exp, input int lim);
        int n;
        n = 0;
        while (level !== exp && n < lim)
        begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        check({16'h0000, level}, {16'h0000, exp});
    endtask

    task automatic hold_chk(input logic [15:0] exp, input int len);
        repeat (len) @(posedge clk);
        #1;
        check({16'h0000, level}, {16'h0000, exp});
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h0);
        rd_chk(ADDR_SLEW, {16'h0000, RST_SLEW});
        rd_chk(ADDR_RETURN, {16'h0000, RST_RETURN});
        rd_chk(ADDR_UPPER, {16'h0000, RST_UPPER});
        rd_chk(ADDR_LOWER, 32'h0);
        rd_chk(8'h1C, 32'h0);
        wr_reg(ADDR_LEVEL, 16'h0100);
        rd_chk(ADDR_LEVEL, 32'h0);
        w_up <= 1'b1;
        hold_chk(16'h0000, 80);
        check({31'h0, active}, 32'h0);
        $display("test inactive done");

        // 2500 a tick: four ticks full scale
        wr_reg(ADDR_SLEW, 16'h0004);
        // the old step would still be in use until the divide finishes
        repeat (40) @(posedge clk);
        rd_chk(ADDR_STATUS, 32'h0);
        wr_reg(ADDR_CTRL, {13'h0, MACRO_RAISE_LOWER});
        rd_chk(ADDR_STATUS, 32'h3);
        wait_lvl(16'h09C4, 100);
        wait_lvl(16'h1388, 9);
        wait_lvl(16'h2710, 40);
        hold_chk(16'h2710, 40);
        $display("test raise done");

        wr_reg(ADDR_LOWER, 16'h03E8);
        w_up <= 1'b0;
        w_dn <= 1'b1;
        wait_lvl(16'h1D4C, 20);
        wait_lvl(16'h03E8, 60);
        hold_chk(16'h03E8, 40);
        $display("test lower done");

        w_up <= 1'b1;
        hold_chk(16'h03E8, 40);
        w_up <= 1'b0;
        w_dn <= 1'b0;
        wr_reg(ADDR_LOWER, 16'h0BB8);
        wait_lvl(16'h0BB8, 20);
        wr_reg(ADDR_LOWER, 16'h0000);
        wr_reg(ADDR_UPPER, 16'h07D0);
        wait_lvl(16'h07D0, 20);
        wr_reg(ADDR_LOWER, 16'h05DC);
        wr_reg(ADDR_UPPER, 16'h05DC);
        hold_chk(16'h05DC, 3);
        rd_chk(ADDR_STATUS, 32'h9);
        wr_reg(ADDR_UPPER, 16'h2710);
        wr_reg(ADDR_LOWER, 16'h0000);
        $display("test hold and limits done");

        wr_reg(ADDR_RETURN, 16'h1234);
        w_rst <= 1'b1;
        w_up <= 1'b1;
        hold_chk(16'h1234, 4);
        hold_chk(16'h1234, 40);
        w_rst <= 1'b0;
        w_up <= 1'b0;
        $display("test reset command done");

        @(posedge clk);
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        hold_chk(16'h1234, 3);
        rd_chk(ADDR_LEVEL, 32'h0000_1234);
        $display("test power down done");
        final_report();
    end
endmodule // raise_lower_ramp_reference_test
`default_nettype wire

// ===== rlr_div_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rlr_div_if;
    logic        start;
    logic [15:0] divisor;
    logic        busy;
    logic [31:0] quotient;
    modport requester (output start, output divisor, input busy, input quotient);
    modport divider   (input start, input divisor, output busy, output quotient);
endinterface
`default_nettype wire

// ===== rlr_pkg.sv
`default_nettype none
package rlr_pkg;
    // ------------------------------------------------------------
    // levels: 0 .. 10000 is 0.00% .. 100.00%
    // ------------------------------------------------------------
    localparam int           LVL_W          = 16;
    localparam int           FRAC_W         = 16;
    localparam int           ACC_W          = LVL_W + FRAC_W;
    localparam logic [15:0]  FULL_SCALE     = 16'h2710;
    localparam logic [31:0]  DIV_DIVIDEND   = {FULL_SCALE, 16'h0000};
    localparam int           DIV_STEPS      = 32;
    localparam logic [5:0]   DIV_STEPS_INIT = 6'h20;

    // ------------------------------------------------------------
    // update tick: 1 ms at a 10 ns clock
    // ------------------------------------------------------------
    localparam int           CLK_PERIOD_NS  = 10;
    localparam int           TICK_TIME_US   = 1000;
    localparam int           TICK_CYCLES    = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int           ADDR_W         = 8;
    localparam logic [7:0]   ADDR_CTRL      = 8'h00;
    localparam logic [7:0]   ADDR_SLEW      = 8'h04;
    localparam logic [7:0]   ADDR_RETURN    = 8'h08;
    localparam logic [7:0]   ADDR_UPPER     = 8'h0C;
    localparam logic [7:0]   ADDR_LOWER     = 8'h10;
    localparam logic [7:0]   ADDR_LEVEL     = 8'h14;
    localparam logic [7:0]   ADDR_STATUS    = 8'h18;

    localparam int           MACRO_W        = 3;
    localparam logic [2:0]   MACRO_RAISE_LOWER = 3'h4;
    localparam logic [2:0]   RST_MACRO      = 3'h0;
    localparam logic [15:0]  RST_SLEW       = 16'h2710;
    localparam logic [15:0]  RST_RETURN     = 16'h0000;
    localparam logic [15:0]  RST_UPPER      = 16'h2710;
    localparam logic [15:0]  RST_LOWER      = 16'h0000;

    localparam int           ST_ACTIVE      = 0;
    localparam int           ST_UP          = 1;
    localparam int           ST_DOWN        = 2;
    localparam int           ST_CONFLICT    = 3;
    localparam int           ST_DIV_BUSY    = 4;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b01,
        DIV_RUN  = 2'b10
    } rlr_div_state_t;
endpackage
`default_nettype wire

// ===== rlr_step_div.sv
`timescale 1ns/10ps
`default_nettype none
module rlr_step_div
(
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    rlr_div_if.divider bus
);
    import rlr_pkg::*;

    rlr_div_state_t state;
    rlr_div_state_t next_state;
    logic [16:0]    rem;
    logic [16:0]    next_rem;
    logic [31:0]    quo;
    logic [31:0]    next_quo;
    logic [31:0]    result;
    logic [31:0]    next_result;
    logic [15:0]    dvs;
    logic [15:0]    next_dvs;
    logic [5:0]     cnt;
    logic [5:0]     next_cnt;
    logic [16:0]    rem_sh;

    // ------------------------------------------------------------
    // restoring divide, one quotient bit per cycle
    // ------------------------------------------------------------
    always_comb
    begin
        next_state  = state;
        next_rem    = rem;
        next_quo    = quo;
        next_result = result;
        next_dvs    = dvs;
        next_cnt    = cnt;
        rem_sh      = {rem[15:0], quo[31]};
        case (state)
            DIV_IDLE:
            begin
                if (bus.start)
                begin
                    next_state = DIV_RUN;
                    next_rem   = '0;
                    next_quo   = DIV_DIVIDEND;
                    next_dvs   = bus.divisor;
                    next_cnt   = DIV_STEPS_INIT;
                end
            end
            DIV_RUN:
            begin
                // zero divisor yields all ones: an immediate full jump
                if (rem_sh >= {1'b0, dvs})
                begin
                    next_rem = rem_sh - {1'b0, dvs};
                    next_quo = {quo[30:0], 1'b1};
                end
                else
                begin
                    next_rem = rem_sh;
                    next_quo = {quo[30:0], 1'b0};
                end
                next_cnt = cnt - 1'b1;
                if (cnt == 6'h01)
                begin
                    next_state  = DIV_IDLE;
                    next_result = next_quo;
                end
            end
            default: next_state = DIV_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state  <= DIV_IDLE;
            rem    <= '0;
            quo    <= '0;
            result <= '0;
            dvs    <= '0;
            cnt    <= '0;
        end
        else
        begin
            state  <= next_state;
            rem    <= next_rem;
            quo    <= next_quo;
            result <= next_result;
            dvs    <= next_dvs;
            cnt    <= next_cnt;
        end
    end

    assign bus.busy     = (state == DIV_RUN);
    assign bus.quotient = result;

    div_bounded_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (bus.start && !bus.busy) |=> bus.busy ##[32:33] !bus.busy)
        else $error("slew divide did not finish in 32 cycles");
endmodule // rlr_step_div
`default_nettype wire

// ===== rlr_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
module rlr_switch_model
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_want_reset,
    input  wire logic        i_want_raise,
    input  wire logic        i_want_lower,
    input  wire logic        i_active,
    input  wire logic [15:0] i_level,
    output logic             o_cmd_reset,
    output logic             o_cmd_raise,
    output logic             o_cmd_lower,
    output logic             o_nv_valid,
    output logic [15:0]      o_nv_level
);
    // ------------------------------------------------------------
    // switch contacts and backup store
    // ------------------------------------------------------------
    initial
    begin
        o_cmd_reset = 1'b0;
        o_cmd_raise = 1'b0;
        o_cmd_lower = 1'b0;
        o_nv_valid  = 1'b0;
        o_nv_level  = 16'h0000;
    end

    always @(posedge i_ref_clk)
    begin
        o_cmd_reset <= i_want_reset;
        o_cmd_raise <= i_want_raise;
        o_cmd_lower <= i_want_lower;
        // saved only while live: the zero shown in device reset must not overwrite it
        if (i_active)
        begin
            o_nv_valid <= 1'b1;
            o_nv_level <= i_level;
        end
    end
endmodule // rlr_switch_model
`default_nettype wire

// ===== rlr_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module rlr_tick_gen
#(
    parameter int TICK_CYCLES = 100000
)
(
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    output logic      o_tick
);
    localparam int TICK_W = $clog2(TICK_CYCLES);
    localparam logic [TICK_W-1:0] LAST = TICK_W'(TICK_CYCLES - 1);

    logic [TICK_W-1:0] cnt;
    logic [TICK_W-1:0] next_cnt;

    always_comb
    begin
        next_cnt = (cnt == LAST) ? '0 : cnt + 1'b1;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end

    assign o_tick = (cnt == LAST);

    tick_single_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_tick |=> !o_tick) else $error("tick lasted more than one cycle");
endmodule // rlr_tick_gen
`default_nettype wire

// ===== rlr_top.sv
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rlr_top
#(
    parameter int TICK_CYCLES = rlr_pkg::TICK_CYCLES
)
(
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_resetn,
    input  wire logic [rlr_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [31:0]                i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [31:0]                o_rdata,
    input  wire logic                       i_cmd_reset,
    input  wire logic                       i_cmd_raise,
    input  wire logic                       i_cmd_lower,
    input  wire logic                       i_nv_valid,
    input  wire logic [rlr_pkg::LVL_W-1:0]  i_nv_level,
    output logic      [rlr_pkg::LVL_W-1:0]  o_level,
    output logic                            o_active
);
    import rlr_pkg::*;

    // step for the reset slew, so a raise moves before the first divide ends
    localparam logic [31:0] RST_STEP = DIV_DIVIDEND / {16'h0000, RST_SLEW};

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [MACRO_W-1:0] macro_sel;
    logic [15:0]        slew_time;
    logic [15:0]        return_level;
    logic [15:0]        upper_limit;
    logic [15:0]        lower_limit;
    logic [ACC_W-1:0]   level;
    logic [31:0]        step;
    logic               div_pend;
    logic               nv_pend;
    logic [31:0]        rdata;

    logic [MACRO_W-1:0] next_macro_sel;
    logic [15:0]        next_slew_time;
    logic [15:0]        next_return_level;
    logic [15:0]        next_upper_limit;
    logic [15:0]        next_lower_limit;
    logic [ACC_W-1:0]   next_level;
    logic [31:0]        next_step;
    logic               next_div_pend;
    logic               next_nv_pend;
    logic [31:0]        next_rdata;

    logic               tick;
    logic               active;
    logic               conflict;
    logic               going_up;
    logic               going_down;
    logic [ACC_W-1:0]   target;
    logic [ACC_W:0]     sum_up;
    logic [ACC_W:0]     sum_dn;
    logic [LVL_W-1:0]   level_int;
    logic               div_done;
    logic               div_busy_q;

    rlr_div_if div_bus ();

    rlr_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick
    (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .o_tick    (tick)
    );

    rlr_step_div u_div
    (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .bus       (div_bus.divider)
    );

    // ------------------------------------------------------------
    // step size: full scale over ramp ticks, recomputed on each ADDR_SLEW write
    // ------------------------------------------------------------
    assign div_bus.start   = div_pend && !div_bus.busy;
    assign div_bus.divisor = slew_time;
    assign div_done        = div_busy_q && !div_bus.busy;

    // ------------------------------------------------------------
    // ramp control
    // ------------------------------------------------------------
    assign level_int = level[ACC_W-1:FRAC_W];
    assign active    = (macro_sel == MACRO_RAISE_LOWER);
    assign conflict  = (upper_limit <= lower_limit);

    always_comb
    begin
        target = level;
        if (i_cmd_raise && !i_cmd_lower)
            target = {upper_limit, 16'h0000};
        else if (i_cmd_lower && !i_cmd_raise)
            target = {lower_limit, 16'h0000};
        else if (level > {upper_limit, 16'h0000})
            target = {upper_limit, 16'h0000};
        else if (level < {lower_limit, 16'h0000})
            target = {lower_limit, 16'h0000};
    end

    assign going_up   = active && !conflict && !i_cmd_reset && (target > level);
    assign going_down = active && !conflict && !i_cmd_reset && (target < level);
    assign sum_up     = {1'b0, level} + {1'b0, step};
    assign sum_dn     = {1'b0, level} - {1'b0, step};

    always_comb
    begin
        next_level   = level;
        next_nv_pend = 1'b0;
        // saved level is reloaded once, on the first edge after reset
        if (nv_pend)
        begin
            if (i_nv_valid)
                next_level = {i_nv_level, 16'h0000};
        end
        else if (active)
        begin
            if (conflict)
                next_level = {upper_limit, 16'h0000};
            else if (i_cmd_reset)
                next_level = {return_level, 16'h0000};
            else if (tick && going_up)
            begin
                // clamp: never step past the target
                if (sum_up[ACC_W] || (sum_up[ACC_W-1:0] >= target))
                    next_level = target;
                else
                    next_level = sum_up[ACC_W-1:0];
            end
            else if (tick && going_down)
            begin
                if (sum_dn[ACC_W] || (sum_dn[ACC_W-1:0] <= target))
                    next_level = target;
                else
                    next_level = sum_dn[ACC_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_comb
    begin
        next_macro_sel    = macro_sel;
        next_slew_time    = slew_time;
        next_return_level = return_level;
        next_upper_limit  = upper_limit;
        next_lower_limit  = lower_limit;
        next_div_pend     = div_pend && div_bus.busy;
        next_step         = div_done ? div_bus.quotient : step;
        next_rdata        = 32'h0000_0000;
        if (div_pend && !div_bus.busy)
            next_div_pend = 1'b0;
        if (i_wr)
        begin
            case (i_addr)
                ADDR_CTRL:   next_macro_sel    = i_wdata[MACRO_W-1:0];
                ADDR_SLEW:
                begin
                    next_slew_time = i_wdata[15:0];
                    next_div_pend  = 1'b1;
                end
                ADDR_RETURN: next_return_level = i_wdata[15:0];
                ADDR_UPPER:  next_upper_limit  = i_wdata[15:0];
                ADDR_LOWER:  next_lower_limit  = i_wdata[15:0];
                default:     next_macro_sel    = macro_sel;
            endcase
        end
        if (i_rd)
        begin
            case (i_addr)
                ADDR_CTRL:   next_rdata = {29'h0, macro_sel};
                ADDR_SLEW:   next_rdata = {16'h0000, slew_time};
                ADDR_RETURN: next_rdata = {16'h0000, return_level};
                ADDR_UPPER:  next_rdata = {16'h0000, upper_limit};
                ADDR_LOWER:  next_rdata = {16'h0000, lower_limit};
                ADDR_LEVEL:  next_rdata = {16'h0000, level_int};
                ADDR_STATUS:
                begin
                    next_rdata[ST_ACTIVE]   = active;
                    next_rdata[ST_UP]       = going_up;
                    next_rdata[ST_DOWN]     = going_down;
                    next_rdata[ST_CONFLICT] = conflict;
                    next_rdata[ST_DIV_BUSY] = div_bus.busy || div_pend;
                end
                default:     next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            macro_sel    <= RST_MACRO;
            slew_time    <= RST_SLEW;
            return_level <= RST_RETURN;
            upper_limit  <= RST_UPPER;
            lower_limit  <= RST_LOWER;
            level        <= '0;
            step         <= RST_STEP;
            div_pend     <= 1'b1;
            nv_pend      <= 1'b1;
            rdata        <= '0;
            div_busy_q   <= 1'b0;
        end
        else
        begin
            macro_sel    <= next_macro_sel;
            slew_time    <= next_slew_time;
            return_level <= next_return_level;
            upper_limit  <= next_upper_limit;
            lower_limit  <= next_lower_limit;
            level        <= next_level;
            step         <= next_step;
            div_pend     <= next_div_pend;
            nv_pend      <= next_nv_pend;
            rdata        <= next_rdata;
            div_busy_q   <= div_bus.busy;
        end
    end

    assign o_rdata  = rdata;
    assign o_level  = level_int;
    assign o_active = active;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    inactive_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!active && !nv_pend) |=> $stable(level))
        else $error("level moved while macro not selected");

    reset_track_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (active && !conflict && i_cmd_reset && !nv_pend)
        |=> level == {$past(return_level), 16'h0000})
        else $error("level did not track return level");

    conflict_force_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (active && conflict && !nv_pend) |=> level_int == $past(upper_limit))
        else $error("limit conflict did not force upper limit");

    raise_stop_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!nv_pend && going_up && tick && i_cmd_raise && !i_cmd_lower)
        |=> (level > $past(level)) && (level <= {$past(upper_limit), 16'h0000}))
        else $error("raise did not move up within the upper limit");

    lower_stop_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!nv_pend && going_down && tick && i_cmd_lower && !i_cmd_raise)
        |=> (level < $past(level)) && (level >= {$past(lower_limit), 16'h0000}))
        else $error("lower did not move down within the lower limit");

    hold_still_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!nv_pend && active && !conflict && !i_cmd_reset && (i_cmd_raise == i_cmd_lower)
         && !going_up && !going_down) |=> $stable(level))
        else $error("level moved while holding inside limits");

    pull_up_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!nv_pend && tick && going_up && (i_cmd_raise == i_cmd_lower))
        |=> (level > $past(level)) && (level <= {$past(lower_limit), 16'h0000}))
        else $error("pull back up did not stop at the lower limit");

    pull_down_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!nv_pend && tick && going_down && (i_cmd_raise == i_cmd_lower))
        |=> (level < $past(level)) && (level >= {$past(upper_limit), 16'h0000}))
        else $error("pull back down did not stop at the upper limit");

    step_size_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!nv_pend && going_up && tick && !sum_up[ACC_W] && (sum_up[ACC_W-1:0] < target))
        |=> level == $past(level) + $past(step))
        else $error("ramp step differs from computed step");

    level_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_rd && (i_addr == ADDR_LEVEL)) |=> o_rdata == {16'h0000, $past(level_int)})
        else $error("level readback wrong");

    raise_hit_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        going_up && tick ##1 (level_int == upper_limit));
    lower_hit_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        going_down && tick ##1 (level_int == lower_limit));
    reset_cmd_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        active && i_cmd_reset && i_cmd_raise);
    conflict_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        active && conflict);
    pullback_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        tick && (going_up || going_down) && (i_cmd_raise == i_cmd_lower));
endmodule // rlr_top
`default_nettype wire
